// File: include/uhrc_defines.svh
`ifndef UHRC_DEFINES_SVH
`define UHRC_DEFINES_SVH

// register byte addresses on the system bus
`define UHRC_REV_ADDR        32'hFFF05000
`define UHRC_CTRL_ADDR       32'hFFF05004

// reset values
`define UHRC_REV_RESET       32'h00000010
`define UHRC_CTRL_RESET      32'h00000000

// revision register field
`define UHRC_REV_LSB         0
`define UHRC_REV_MSB         7

// control register field positions
`define UHRC_CBR_LSB         0
`define UHRC_CBR_MSB         1
`define UHRC_PLE_BIT         2
`define UHRC_ISE_BIT         3
`define UHRC_CLE_BIT         4
`define UHRC_BLE_BIT         5
`define UHRC_FS_LSB          6
`define UHRC_FS_MSB          7
`define UHRC_IR_BIT          8
`define UHRC_RWC_BIT         9
`define UHRC_REMOTE_WAKE_CONNECTED_EN_BIT        10

// ahb encodings
`define UHRC_HRESP_OKAY      2'h0
`define UHRC_HSIZE_BYTE      3'h0
`define UHRC_HSIZE_HALF      3'h1

`endif

// File: include/uhrc_pkg.sv
package uhrc_pkg;

	// controller functional state, declaration order gives the 2-bit field code
	typedef enum logic [1:0] {
		UHRC_FS_RESET,
		UHRC_FS_RESUME,
		UHRC_FS_OPER,
		UHRC_FS_SUSPEND
	} uhrc_fstate_t;

	// which asynchronous list is being served
	typedef enum logic {
		UHRC_SRV_CTL,
		UHRC_SRV_BLK
	} uhrc_srv_t;

endpackage

// File: hw/uhrc_frame.sv
`timescale 1ns/1ps
`default_nettype none

module uhrc_frame
	import uhrc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	input  wire logic frame_start_in,
	input  wire logic oper_in,
	input  wire logic periodic_on_in,
	input  wire logic iso_on_in,
	input  wire logic iso_ed_in,
	input  wire logic int_ed_in,
	output logic      periodic_go_out,
	output logic      ed_serve_out,
	output logic      ed_skip_out
);

	logic periodic_go_r;
	logic ed_serve_r;
	logic ed_skip_r;
	logic any_ed;
	logic serve_nxt;

	// iso is checked live when the descriptor is met, periodic only at frame start
	assign any_ed    = iso_ed_in | int_ed_in;
	assign serve_nxt = periodic_go_r & (int_ed_in | (iso_ed_in & iso_on_in)); // [RL9] [RL10]

	// sample once per frame so a mid-frame toggle cannot cut a periodic phase in half
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			periodic_go_r <= 1'b0;
			ed_serve_r    <= 1'b0;
			ed_skip_r     <= 1'b0;
		end else if (ce_in) begin
			if (frame_start_in) begin
				periodic_go_r <= periodic_on_in & oper_in; // [RL11] [RL10]
			end
			ed_serve_r <= serve_nxt;
			ed_skip_r  <= any_ed & ~serve_nxt; // [RL9]
		end
	end

	assign periodic_go_out = periodic_go_r;
	assign ed_serve_out    = ed_serve_r;
	assign ed_skip_out     = ed_skip_r;

endmodule

`default_nettype wire

// File: hw/uhrc_ratio.sv
`timescale 1ns/1ps
`default_nettype none

module uhrc_ratio
	import uhrc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic       oper_in,
	input  wire logic       ctl_on_in,
	input  wire logic       blk_on_in,
	input  wire logic       ctl_ready_in,
	input  wire logic       blk_ready_in,
	input  wire logic       ed_done_in,
	input  wire logic [1:0] ratio_in,
	output logic            serve_ctl_out,
	output logic            serve_blk_out
);

	uhrc_srv_t  srv_r;
	uhrc_srv_t  srv_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic       ctl_ok;
	logic       blk_ok;
	logic       serve_ctl_r;
	logic       serve_blk_r;

	// a list takes part only when enabled and holding work
	assign ctl_ok = oper_in & ctl_on_in & ctl_ready_in; // [RL8]
	assign blk_ok = oper_in & blk_on_in & blk_ready_in; // [RL7]

	// n control eds per bulk ed, field holds n-1; an idle list never blocks the other
	always_comb begin
		srv_nxt = srv_r;
		cnt_nxt = cnt_r;
		case (srv_r)
			UHRC_SRV_CTL: begin
				if (!ctl_ok && blk_ok) begin
					srv_nxt = UHRC_SRV_BLK;
					cnt_nxt = 2'h0;
				end else if (ed_done_in) begin
					if (cnt_r >= ratio_in && blk_ok) begin // [RL12]
						srv_nxt = UHRC_SRV_BLK;
						cnt_nxt = 2'h0;
					end else if (cnt_r < ratio_in) begin
						cnt_nxt = cnt_r + 2'h1;
					end
				end
			end
			UHRC_SRV_BLK: begin
				if ((ed_done_in || !blk_ok) && ctl_ok) begin
					srv_nxt = UHRC_SRV_CTL;
					cnt_nxt = 2'h0;
				end
			end
			default: begin
				srv_nxt = UHRC_SRV_CTL;
				cnt_nxt = 2'h0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			srv_r       <= UHRC_SRV_CTL;
			cnt_r       <= 2'h0;
			serve_ctl_r <= 1'b0;
			serve_blk_r <= 1'b0;
		end else if (ce_in) begin
			srv_r       <= srv_nxt;
			cnt_r       <= cnt_nxt;
			serve_ctl_r <= (srv_nxt == UHRC_SRV_CTL) & ctl_ok; // [RL8]
			serve_blk_r <= (srv_nxt == UHRC_SRV_BLK) & blk_ok; // [RL7]
		end
	end

	assign serve_ctl_out = serve_ctl_r;
	assign serve_blk_out = serve_blk_r;

endmodule

`default_nettype wire

// File: hw/uhrc_top.sv
// Behaviour
// RL1: the revision register reads hex 10 in its low byte, meaning interface revision 1.0.
// RL2: the remote wakeup connected enable bit 10 is stored but drives nothing.
// RL3: the remote wakeup support bit 9 always reads zero.
// RL4: control bit 8 sends interrupts to the normal output when clear and to the system management output when set.
// RL5: control bits 7:6 pick reset, resume, operational or suspend as 00, 01, 10, 11.
// RL6: in suspend, detected downstream resume signalling moves the state field to resume by itself.
// RL7: bulk list work is done only while control bit 5 is set.
// RL8: control list work is done only while control bit 4 is set.
// RL9: an isochronous descriptor met in the periodic list is skipped while bit 3 is clear; interrupt ones still run.
// RL10: periodic list work is done only while control bit 2 is set.
// RL11: the periodic enable is sampled at each frame start before any periodic transfer.
// RL12: bits 1:0 give control endpoints served per bulk endpoint, coded as count minus one.
// RL13: reserved bits of both registers read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "uhrc_defines.svh"

module uhrc_top
	import uhrc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	// ahb slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hready_out,
	output logic      [1:0]  hresp_out,
	// controller side
	input  wire logic        irq_event_in,
	input  wire logic        resume_detect_in,
	input  wire logic        frame_start_in,
	input  wire logic        iso_ed_in,
	input  wire logic        int_ed_in,
	input  wire logic        ctl_ready_in,
	input  wire logic        blk_ready_in,
	input  wire logic        ed_done_in,
	output logic             normal_irq_out,
	output logic             smi_irq_out,
	output logic      [1:0]  functional_state_out,
	output logic             bulk_list_on_out,
	output logic             control_list_on_out,
	output logic             periodic_go_out,
	output logic             ed_serve_out,
	output logic             ed_skip_out,
	output logic             serve_ctl_out,
	output logic             serve_blk_out
);

	// reset release synchroniser
	logic rst_meta_r;
	logic rst_sync_r;
	logic rst_n;

	// ahb data phase state
	logic       dp_valid_r;
	logic       dp_write_r;
	logic       dp_ctrl_r;
	logic [3:0] dp_lanes_r;

	// control register fields
	logic         remote_wake_connected_en_r;
	logic         ir_r;
	uhrc_fstate_t fs_r;
	logic         ble_r;
	logic         cle_r;
	logic         ise_r;
	logic         ple_r;
	logic [1:0]   cbr_r;

	// next values
	logic         remote_wake_connected_en_nxt;
	logic         ir_nxt;
	uhrc_fstate_t fs_nxt;
	uhrc_fstate_t fs_sw;
	logic         ble_nxt;
	logic         cle_nxt;
	logic         ise_nxt;
	logic         ple_nxt;
	logic [1:0]   cbr_nxt;

	// output registers
	logic [31:0] hrdata_r;
	logic [31:0] hrdata_nxt;
	logic        hready_r;
	logic [1:0]  hresp_r;
	logic        normal_irq_r;
	logic        smi_irq_r;
	logic [1:0]  fs_out_r;
	logic        ble_out_r;
	logic        cle_out_r;

	// decode
	logic        ap_valid;
	logic        ap_read;
	logic        ap_rev;
	logic        ap_ctrl;
	logic [3:0]  ap_lanes;
	logic        wr_ctrl;
	logic [7:0]  wr_byte0;
	logic [7:0]  wr_byte1;
	logic [31:0] ctrl_view;
	logic [31:0] ctrl_nxt_view;
	logic [31:0] rev_view;
	logic        oper;

	// hold the release for two edges so all flops leave reset on the same edge
	// ce_in is left out here so a frozen block still comes out of reset cleanly
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign rst_n = rst_sync_r;

	// address phase decode; full address compare, anything else reads zero
	assign ap_valid = hsel_in & hready_in & htrans_in[1];
	assign ap_read  = ap_valid & ~hwrite_in;
	// whole-word compare at full width, so the low address bits only pick byte lanes
	assign ap_rev   = ({haddr_in[31:2], 2'h0} == `UHRC_REV_ADDR);
	assign ap_ctrl  = ({haddr_in[31:2], 2'h0} == `UHRC_CTRL_ADDR);

	// byte lanes from size and low address bits
	assign ap_lanes = (hsize_in == `UHRC_HSIZE_BYTE) ? (4'h1 << haddr_in[1:0]) :
	                  (hsize_in == `UHRC_HSIZE_HALF) ? (haddr_in[1] ? 4'hC : 4'h3) :
	                  4'hF;

	// capture the address phase for the following data phase
	// hready_in low stretches the previous data phase, so the capture waits for it
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_ctrl_r  <= 1'b0;
			dp_lanes_r <= 4'h0;
		end else if (ce_in && hready_in) begin
			dp_valid_r <= ap_valid;
			dp_write_r <= hwrite_in;
			dp_ctrl_r  <= ap_ctrl;
			dp_lanes_r <= ap_lanes;
		end
	end

	// write data arrives in the data phase; unselected lanes keep their value
	assign wr_ctrl  = dp_valid_r & dp_write_r & dp_ctrl_r;
	assign wr_byte0 = dp_lanes_r[0] ? hwdata_in[7:0] : ctrl_view[7:0];
	assign wr_byte1 = dp_lanes_r[1] ? hwdata_in[15:8] : ctrl_view[15:8];

	// stored fields; upper bytes have nothing to hold
	assign remote_wake_connected_en_nxt = wr_ctrl ? wr_byte1[`UHRC_REMOTE_WAKE_CONNECTED_EN_BIT - 8] : remote_wake_connected_en_r; // [RL2] [RL13]
	assign ir_nxt   = wr_ctrl ? wr_byte1[`UHRC_IR_BIT - 8] : ir_r;
	assign fs_sw    = wr_ctrl ? uhrc_fstate_t'(wr_byte0[`UHRC_FS_MSB:`UHRC_FS_LSB]) : fs_r; // [RL5]
	assign ble_nxt  = wr_ctrl ? wr_byte0[`UHRC_BLE_BIT] : ble_r;
	assign cle_nxt  = wr_ctrl ? wr_byte0[`UHRC_CLE_BIT] : cle_r;
	assign ise_nxt  = wr_ctrl ? wr_byte0[`UHRC_ISE_BIT] : ise_r;
	assign ple_nxt  = wr_ctrl ? wr_byte0[`UHRC_PLE_BIT] : ple_r;
	assign cbr_nxt  = wr_ctrl ? wr_byte0[`UHRC_CBR_MSB:`UHRC_CBR_LSB] : cbr_r;

	// hardware resume beats a same-cycle software write so the wakeup is not lost
	always_comb begin
		fs_nxt = fs_sw;
		case (fs_r)
			UHRC_FS_SUSPEND: begin
				if (resume_detect_in) begin
					fs_nxt = UHRC_FS_RESUME; // [RL6]
				end
			end
			UHRC_FS_RESET,
			UHRC_FS_RESUME,
			UHRC_FS_OPER: begin
				fs_nxt = fs_sw;
			end
			default: begin
				fs_nxt = UHRC_FS_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			remote_wake_connected_en_r <= 1'b0;
			ir_r   <= 1'b0;
			fs_r   <= UHRC_FS_RESET;
			ble_r  <= 1'b0;
			cle_r  <= 1'b0;
			ise_r  <= 1'b0;
			ple_r  <= 1'b0;
			cbr_r  <= 2'h0;
		end else if (ce_in) begin
			remote_wake_connected_en_r <= remote_wake_connected_en_nxt;
			ir_r   <= ir_nxt;
			fs_r   <= fs_nxt;
			ble_r  <= ble_nxt;
			cle_r  <= cle_nxt;
			ise_r  <= ise_nxt;
			ple_r  <= ple_nxt;
			cbr_r  <= cbr_nxt;
		end
	end

	// register views; reserved bits and the wakeup support bit are tied low
	assign ctrl_view = {21'h0, remote_wake_connected_en_r, 1'b0, ir_r, fs_r, ble_r, cle_r, ise_r, ple_r, cbr_r}; // [RL3] [RL13]
	assign rev_view  = `UHRC_REV_RESET; // [RL1] [RL13]

	// next-value view lets a read straight after a control write return the new value
	assign ctrl_nxt_view = {21'h0, remote_wake_connected_en_nxt, 1'b0, ir_nxt, fs_nxt, ble_nxt, cle_nxt,
	                        ise_nxt, ple_nxt, cbr_nxt}; // [RL3] [RL13]

	// read data is sampled at the address phase so it stands through the data phase;
	// a read right after a control write sees the newly written value
	assign hrdata_nxt = !ap_read ? 32'h0 :
	                    ap_rev   ? rev_view :
	                    ap_ctrl  ? ctrl_nxt_view :
	                    32'h0;

	// zero wait states, always okay; unmapped words read zero and drop writes
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_r <= 32'h0;
			hready_r <= 1'b1;
			hresp_r  <= `UHRC_HRESP_OKAY;
		end else if (ce_in && hready_in) begin
			hrdata_r <= hrdata_nxt;
			hready_r <= 1'b1;
			hresp_r  <= `UHRC_HRESP_OKAY;
		end
	end

	assign oper = (fs_r == UHRC_FS_OPER);

	// interrupt steering and exported control; one flop of latency on each
	// routing reads the stored bit, so a bit 8 write moves only later requests
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			normal_irq_r <= 1'b0;
			smi_irq_r    <= 1'b0;
			fs_out_r     <= 2'h0;
			ble_out_r    <= 1'b0;
			cle_out_r    <= 1'b0;
		end else if (ce_in) begin
			normal_irq_r <= irq_event_in & ~ir_r; // [RL4]
			smi_irq_r    <= irq_event_in & ir_r;  // [RL4]
			fs_out_r     <= fs_r;                 // [RL5]
			ble_out_r    <= ble_r & oper;         // [RL7]
			cle_out_r    <= cle_r & oper;         // [RL8]
		end
	end

	// periodic phase gating per frame
	// list processor strobes share this clock, so they need no synchroniser
	uhrc_frame u_frame (
		.clk_in          (clk_in),
		.rst_n_in        (rst_n),
		.ce_in           (ce_in),
		.frame_start_in  (frame_start_in),
		.oper_in         (oper),
		.periodic_on_in  (ple_r),
		.iso_on_in       (ise_r),
		.iso_ed_in       (iso_ed_in),
		.int_ed_in       (int_ed_in),
		.periodic_go_out (periodic_go_out),
		.ed_serve_out    (ed_serve_out),
		.ed_skip_out     (ed_skip_out)
	);

	// control versus bulk service ratio
	uhrc_ratio u_ratio (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n),
		.ce_in         (ce_in),
		.oper_in       (oper),
		.ctl_on_in     (cle_r),
		.blk_on_in     (ble_r),
		.ctl_ready_in  (ctl_ready_in),
		.blk_ready_in  (blk_ready_in),
		.ed_done_in    (ed_done_in),
		.ratio_in      (cbr_r),
		.serve_ctl_out (serve_ctl_out),
		.serve_blk_out (serve_blk_out)
	);

	assign hrdata_out           = hrdata_r;
	assign hready_out           = hready_r;
	assign hresp_out            = hresp_r;
	assign normal_irq_out       = normal_irq_r;
	assign smi_irq_out          = smi_irq_r;
	assign functional_state_out = fs_out_r;
	assign bulk_list_on_out     = ble_out_r;
	assign control_list_on_out  = cle_out_r;

endmodule

`default_nettype wire

// File: verification/uhrc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

module uhrc_top_sva (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic       irq_event_in,
	input  wire logic       frame_start_in,
	input  wire logic       iso_ed_in,
	input  wire logic       int_ed_in,
	input  wire logic       normal_irq_out,
	input  wire logic       smi_irq_out,
	input  wire logic [1:0] functional_state_out,
	input  wire logic       bulk_list_on_out,
	input  wire logic       control_list_on_out,
	input  wire logic       periodic_go_out,
	input  wire logic       ed_serve_out,
	input  wire logic       ed_skip_out,
	input  wire logic       serve_ctl_out,
	input  wire logic       serve_blk_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// a descriptor pulse one edge back is the only cause of a serve or skip
	sequence ed_seen;
		$past(iso_ed_in || int_ed_in);
	endsequence

	irq_route_a: assert property (!(normal_irq_out && smi_irq_out)) else $error("both irq outputs high");
	irq_cause_a: assert property ((normal_irq_out || smi_irq_out) && $past(ce_in) |-> $past(irq_event_in))
		else $error("irq without event");
	bulk_gate_a: assert property (bulk_list_on_out |-> functional_state_out == 2'h2) else $error("bulk on");
	ctl_gate_a: assert property (control_list_on_out |-> functional_state_out == 2'h2) else $error("ctl on");
	// periodic permission may only move at a frame boundary
	frame_hold_a: assert property (!frame_start_in |=> $stable(periodic_go_out)) else $error("go moved");
	frame_take_a: assert property ($rose(periodic_go_out) |->
		$past(frame_start_in) && functional_state_out == 2'h2) else $error("go rose badly");
	ed_excl_a: assert property (!(ed_serve_out && ed_skip_out)) else $error("serve and skip");
	ed_cause_a: assert property ($past(ce_in) && (ed_serve_out || ed_skip_out) |-> ed_seen) else $error("no ed");
	ed_period_a: assert property (ed_serve_out |-> $past(periodic_go_out)) else $error("served while off");
	serve_excl_a: assert property (!(serve_ctl_out && serve_blk_out)) else $error("two lists");
endmodule

bind uhrc_top uhrc_top_sva chk_u (
	.clk_in               (clk_in),
	.rst_n_in             (rst_n_in),
	.ce_in                (ce_in),
	.irq_event_in         (irq_event_in),
	.frame_start_in       (frame_start_in),
	.iso_ed_in            (iso_ed_in),
	.int_ed_in            (int_ed_in),
	.normal_irq_out       (normal_irq_out),
	.smi_irq_out          (smi_irq_out),
	.functional_state_out (functional_state_out),
	.bulk_list_on_out     (bulk_list_on_out),
	.control_list_on_out  (control_list_on_out),
	.periodic_go_out      (periodic_go_out),
	.ed_serve_out         (ed_serve_out),
	.ed_skip_out          (ed_skip_out),
	.serve_ctl_out        (serve_ctl_out),
	.serve_blk_out        (serve_blk_out)
);

`default_nettype wire

// File: verification/uhrc_lists_model.sv
`timescale 1ns/1ps
`default_nettype none

module uhrc_lists_model #(
	parameter int FRAME = 40,
	parameter int GAP   = 3
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic serving_in,
	output logic      frame_start_out,
	output logic      iso_ed_out,
	output logic      int_ed_out,
	output logic      ed_done_out
);
	int cnt;
	int gap_cnt;

	// frame timer with one iso and one interrupt descriptor per frame; GAP sets how slowly an ed completes
	always @(negedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 0;
			gap_cnt <= 0;
			frame_start_out <= 1'b0;
			iso_ed_out <= 1'b0;
			int_ed_out <= 1'b0;
			ed_done_out <= 1'b0;
		end else begin
			cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
			frame_start_out <= (cnt == FRAME - 1);
			iso_ed_out <= (cnt == 3);
			int_ed_out <= (cnt == 6);
			gap_cnt <= (serving_in && gap_cnt < GAP) ? gap_cnt + 1 : 0;
			ed_done_out <= serving_in && gap_cnt == GAP;
		end
	end
endmodule

`default_nettype wire

// File: verification/usb_host_revision_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhrc_defines.svh"

module usb_host_revision_control_test;
	import uhrc_pkg::*;
	logic        clk_in, rst_n_in, ce_in, hsel_in, hwrite_in, hready_in, irq_event_in, resume_detect_in;
	logic [1:0]  htrans_in, hresp_out, functional_state_out, control_bulk_ratio;
	logic [2:0]  hsize_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out;
	logic        hready_out, frame_start_in, iso_ed_in, int_ed_in, rdy, ed_done_in, normal_irq_out, smi_irq_out;
	logic        bulk_list_on_out, control_list_on_out, periodic_go_out, ed_serve_out, ed_skip_out;
	logic        serve_ctl_out, serve_blk_out, ratio_on;
	int          errors, n_tests, n_srv, n_skp, run, n_blk;
	logic [31:0] cfg [3] = '{32'h80, 32'h84, 32'h8C};

	uhrc_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(hready_in), .hrdata_out(hrdata_out), .hready_out(hready_out), .hresp_out(hresp_out),
		.irq_event_in(irq_event_in), .resume_detect_in(resume_detect_in), .frame_start_in(frame_start_in),
		.iso_ed_in(iso_ed_in), .int_ed_in(int_ed_in), .ctl_ready_in(rdy), .blk_ready_in(rdy),
		.ed_done_in(ed_done_in), .normal_irq_out(normal_irq_out), .smi_irq_out(smi_irq_out),
		.functional_state_out(functional_state_out), .bulk_list_on_out(bulk_list_on_out),
		.control_list_on_out(control_list_on_out), .periodic_go_out(periodic_go_out),
		.ed_serve_out(ed_serve_out), .ed_skip_out(ed_skip_out), .serve_ctl_out(serve_ctl_out),
		.serve_blk_out(serve_blk_out));

	uhrc_lists_model lists_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .serving_in(serve_ctl_out | serve_blk_out),
		.frame_start_out(frame_start_in), .iso_ed_out(iso_ed_in), .int_ed_out(int_ed_in),
		.ed_done_out(ed_done_in));

	assign rdy = rst_n_in;

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	task fail(string m);
		errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task chk(logic [31:0] g, logic [31:0] e, string m);
		n_tests++;
		if (g !== e) fail(m);
	endtask

	// one transfer: address phase, then data phase with the bus left idle
	task bus(logic w, logic [31:0] a, logic [31:0] d, logic [2:0] sz);
		@(negedge clk_in);
		hsel_in = 1'b1;
		haddr_in = a;
		hwrite_in = w;
		hsize_in = sz;
		htrans_in = 2'h2;
		@(negedge clk_in);
		hsel_in = 1'b0;
		htrans_in = 2'h0;
		hwdata_in = d;
	endtask

	task wr(logic [31:0] a, logic [31:0] d);
		bus(1'b1, a, d, 3'h2);
		repeat (2) @(negedge clk_in);
	endtask

	task rd(logic [31:0] a, logic [31:0] e, string m);
		bus(1'b0, a, 32'h0, 3'h2);
		chk(hrdata_out, e, m);
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// tally descriptor outcomes and the control-to-bulk rhythm
	always @(posedge clk_in) begin
		if (ed_serve_out === 1'b1) n_srv++;
		if (ed_skip_out === 1'b1) n_skp++;
		if (ratio_on && ed_done_in && serve_blk_out === 1'b1) begin
			n_tests++;
			if (n_blk > 0 && run != control_bulk_ratio + 1) fail("ratio run");
			n_blk++;
			run = 0;
		end else if (ratio_on && ed_done_in && serve_ctl_out === 1'b1) run++;
	end

	// watchdog so a stuck run still reports
	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		end_of_test;
	end

	initial begin
		{rst_n_in, hsel_in, hwrite_in, irq_event_in, resume_detect_in, ratio_on} = '0;
		{ce_in, hready_in} = 2'h3;
		{htrans_in, hsize_in, haddr_in, hwdata_in, control_bulk_ratio} = '0;
		{errors, n_tests, n_srv, n_skp, run, n_blk} = '0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		chk({hready_out, hresp_out}, 32'h4, "bus idle answer");
		rd(`UHRC_REV_ADDR, 32'h10, "revision");
		rd(`UHRC_CTRL_ADDR, 32'h0, "control reset");
		rd(32'hFFF05008, 32'h0, "unmapped");
		wr(`UHRC_REV_ADDR, '1);
		wr(`UHRC_CTRL_ADDR, '1);
		rd(`UHRC_REV_ADDR, 32'h10, "revision after write");
		rd(`UHRC_CTRL_ADDR, 32'h5FF, "control mask");
		bus(1'b1, `UHRC_CTRL_ADDR + 1, 32'h0, 3'h0);
		rd(`UHRC_CTRL_ADDR, 32'h0FF, "byte lane write");
		ce_in = 1'b0;
		wr(`UHRC_CTRL_ADDR, 32'h0);
		ce_in = 1'b1;
		rd(`UHRC_CTRL_ADDR, 32'h0FF, "frozen by enable");
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			wr(`UHRC_CTRL_ADDR, {24'h0, s[1:0], 6'h30});
			chk({30'h0, functional_state_out}, s, "state field");
			chk({31'h0, bulk_list_on_out}, s == 2, "bulk enable");
			chk({31'h0, control_list_on_out}, s == 2, "control enable");
		end
		resume_detect_in = 1'b1;
		@(negedge clk_in);
		resume_detect_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk({30'h0, functional_state_out}, 32'h1, "hardware resume");
		rd(`UHRC_CTRL_ADDR, 32'h70, "resume readback");
		$display("test states done");
		irq_event_in = 1'b1;
		for (int r = 0; r < 2; r++) begin
			wr(`UHRC_CTRL_ADDR, {23'h0, r[0], 8'h0});
			chk({normal_irq_out, smi_irq_out}, {30'h0, !r[0], r[0]}, "irq routing");
		end
		irq_event_in = 1'b0;
		$display("test interrupts done");
		for (int i = 0; i < 3; i++) begin
			wr(`UHRC_CTRL_ADDR, cfg[i]);
			repeat (45) @(negedge clk_in);
			{n_srv, n_skp} = '0;
			repeat (80) @(negedge clk_in);
			chk({31'h0, periodic_go_out}, cfg[i][2], "periodic permission");
			chk(n_srv > 0, cfg[i][2], "descriptors served");
			chk(n_skp > 0, !cfg[i][2] || !cfg[i][3], "descriptors skipped");
		end
		$display("test periodic done");
		for (int c = 0; c < 4; c++) begin
			wr(`UHRC_CTRL_ADDR, 32'hB0 | c);
			control_bulk_ratio = c[1:0];
			n_blk = 0;
			ratio_on = 1'b1;
			repeat (120) @(negedge clk_in);
			ratio_on = 1'b0;
			chk(n_blk >= 2, 32'h1, "bulk served");
		end
		$display("test ratio done");
		end_of_test;
	end
endmodule

`default_nettype wire
